// [adc_setup_consts.svh]
`ifndef ADC_SETUP_CONSTS_SVH
`define ADC_SETUP_CONSTS_SVH

// ----------------------------------------
// Setup word geometry
// ----------------------------------------
`define SETUP_WIDTH 24
`define SETUP_UPPER_WIDTH 6
`define SETUP_RESET 24'h000117

// ----------------------------------------
// Channel and gain encodings
// ----------------------------------------
`define NUM_CHANNELS 10
`define CHAN_IDX_W 4
`define GAIN_W 3
`define GAIN_UNITY 3'h0
`define GAIN_RESERVED 3'h1
`define RESERVED_BIT_VALUE 1'h0

// ----------------------------------------
// Conversion timing and data
// ----------------------------------------
`define SETTLE_CYCLES_DEFAULT 16
`define DATA_WIDTH 24

`endif

// [adc_setup_pkg.sv]
`include "adc_setup_consts.svh"

package adc_setup_pkg;

    // ----------------------------------------
    // Setup word layout, most significant first
    // ----------------------------------------
    typedef struct packed {
        logic [`SETUP_UPPER_WIDTH-1:0] upperFields; // Kept as written
        logic [`NUM_CHANNELS-1:0] channelEnableBits; // Short,temp,7..0
        logic burnout; // Probe current request
        logic referencePresenceCheckEnable; // Reference detect on
        logic reservedZero; // Always zero
        logic bufferOn; // Input buffer in path
        logic unipolar; // Set: unipolar coding
        logic [`GAIN_W-1:0] gainSelect; // Input range code
    } setup_s;

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_SETTLE = 1'b1
    } seq_state_e;

endpackage

// [channel_sequencer.sv]
`timescale 1ns/1ps
`include "adc_setup_consts.svh"

module channel_sequencer #(
    parameter int NUM_CH = `NUM_CHANNELS,
    parameter int IDX_W = `CHAN_IDX_W,
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [NUM_CH-1:0] enables,
    output logic [IDX_W-1:0] channel,
    output logic startPulse,
    output logic donePulse,
    output logic busy
);

    // ----------------------------------------
    // Local sizing
    // ----------------------------------------
    localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYCLES - 1);
    localparam logic [IDX_W-1:0] IDX_TOP = IDX_W'(NUM_CH - 1);

    adc_setup_pkg::seq_state_e state; // Current state
    adc_setup_pkg::seq_state_e next_state; // State after this edge
    logic [CNT_W-1:0] count; // Settling cycles left
    logic [CNT_W-1:0] next_count; // Counter after this edge
    logic [IDX_W-1:0] next_channel; // Channel after this edge
    logic next_start; // Conversion begins
    logic next_done; // Conversion result due
    logic anyEnabled; // At least one channel on

    // ----------------------------------------
    // Next enabled channel after cur, wrapping
    // ----------------------------------------
    function automatic logic [IDX_W-1:0] nextChannel(
        input logic [NUM_CH-1:0] en,
        input logic [IDX_W-1:0] cur
    );
        logic [IDX_W-1:0] pick;
        int i;
        int k;
        pick = cur;
        // Downward scan so the nearest candidate wins
        for (i = NUM_CH; i >= 1; i--) begin
            k = (int'(cur) + i) % NUM_CH;
            if (en[k]) begin
                pick = IDX_W'(k);
            end
        end
        return pick;
    endfunction

    assign anyEnabled = |enables;
    assign busy = (state == adc_setup_pkg::SEQ_SETTLE);

    // ----------------------------------------
    // Sequencing decisions
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_count = count;
        next_channel = channel;
        next_start = 1'b0;
        next_done = 1'b0;
        unique case (state)
            adc_setup_pkg::SEQ_IDLE: begin
                // Start from the lowest enabled channel
                if (run && anyEnabled) begin
                    next_state = adc_setup_pkg::SEQ_SETTLE;
                    next_channel = nextChannel(enables, IDX_TOP);
                    next_count = CNT_LAST;
                    next_start = 1'b1;
                end
            end
            adc_setup_pkg::SEQ_SETTLE: begin
                if (count != '0) begin
                    next_count = count - CNT_W'(1);
                end else begin
                    next_done = 1'b1;
                    if (run && anyEnabled) begin
                        next_channel = nextChannel(enables, channel);
                        next_count = CNT_LAST;
                        next_start = 1'b1;
                    end else begin
                        next_state = adc_setup_pkg::SEQ_IDLE;
                    end
                end
            end
        endcase
    end

    // ----------------------------------------
    // State, counter and channel registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= adc_setup_pkg::SEQ_IDLE;
            count <= '0;
            channel <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
            channel <= next_channel;
        end
    end

    // ----------------------------------------
    // Event pulses, one cycle each
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            startPulse <= 1'b0;
            donePulse <= 1'b0;
        end else begin
            startPulse <= next_start;
            donePulse <= next_done;
        end
    end

endmodule

// [adc_channel_range_setup.sv]
`timescale 1ns/1ps
`include "adc_setup_consts.svh"

module adc_channel_range_setup #(
    parameter int NUM_CH = `NUM_CHANNELS,
    parameter int IDX_W = `CHAN_IDX_W,
    parameter int DATA_W = `DATA_WIDTH,
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic setupWrite,
    input wire logic [`SETUP_WIDTH-1:0] setupWriteData,
    output logic [`SETUP_WIDTH-1:0] setupReadData,
    output logic setupWriteDone,
    input wire logic convertRun,
    input wire logic refBelowThreshold,
    input wire logic [DATA_W-1:0] filterData,
    output logic bufferEnable,
    output logic burnoutEnable,
    output logic unipolarCoding,
    output logic [`GAIN_W-1:0] gainSelect,
    output logic [IDX_W-1:0] channelSelect,
    output logic conversionStart,
    output logic converting,
    output logic resultValid,
    output logic [DATA_W-1:0] resultData,
    output logic [IDX_W-1:0] resultChannel,
    output logic resultUnipolar,
    output logic [`GAIN_W-1:0] resultGain,
    output logic missingReferenceFlag
);

    // ----------------------------------------
    // Setup word field map
    // ----------------------------------------
    // [23:18] upper fields, stored but not used here
    // [17:8] channel enables, index 9 is the short,
    // index 8 the temperature sensor
    // [7] probe current request
    // [6] reference presence check
    // [5] reserved, always reads zero
    // [4] input buffer in the path
    // [3] unipolar coding when set
    // [2:0] gain code, code one refused
    // Only the lower fields steer anything here.

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    // All host written state lives in this block
    // Word as the host sees it
    adc_setup_pkg::setup_s setupWord;
    // Copy frozen for the conversion in flight
    adc_setup_pkg::setup_s activeSetup;
    // Cleaned value of an incoming write
    adc_setup_pkg::setup_s next_setupWord;

    // Sequencer hookup
    logic [IDX_W-1:0] seqChannel; // Channel being converted
    logic seqStart; // A conversion begins
    logic seqDone; // A conversion has settled
    logic seqBusy; // Converter actively converting
    // Channel of the conversion being settled
    logic [IDX_W-1:0] activeChannel;

    // ----------------------------------------
    // Write cleaning
    // ----------------------------------------
    // Forces the reserved bit low and refuses the
    // reserved gain code, keeping the old gain so the
    // front end never sees an undefined range.
    // Other fields of such a write still land, so a
    // bad gain code never costs the host its channels.
    // Upper fields pass untouched for their owners.
    function automatic adc_setup_pkg::setup_s cleanWrite(
        input logic [`SETUP_WIDTH-1:0] raw,
        input adc_setup_pkg::setup_s old
    );
        adc_setup_pkg::setup_s w;
        w = adc_setup_pkg::setup_s'(raw);
        w.reservedZero = `RESERVED_BIT_VALUE;
        if (w.gainSelect == `GAIN_RESERVED) begin
            w.gainSelect = old.gainSelect;
        end
        return w;
    endfunction

    always_comb begin
        next_setupWord = cleanWrite(setupWriteData, setupWord);
    end

    // ----------------------------------------
    // Host visible setup word
    // ----------------------------------------
    // Holds its value until the next write; reset
    // selects channel 0, buffer on, top gain code.
    // A write and a conversion end on one edge: the
    // conversion keeps its copy, the write wins here.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            setupWord <= adc_setup_pkg::setup_s'(`SETUP_RESET);
        end else if (setupWrite) begin
            setupWord <= next_setupWord;
        end
    end

    // Read back straight from the flops
    assign setupReadData = setupWord;

    // ----------------------------------------
    // Write completion pulse
    // ----------------------------------------
    // Follows every accepted write, refused gain too
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            setupWriteDone <= 1'b0;
        end else begin
            setupWriteDone <= setupWrite;
        end
    end

    // ----------------------------------------
    // Channel sequencer
    // ----------------------------------------
    // Channel choice reads the live enables, so a
    // rewrite changes the order from the next pick.
    // A calibration expects exactly one enable; the
    // sequencer then simply repeats that channel.
    // Dropping convertRun lets the conversion in
    // flight finish and deliver its result.
    // Timing: the start pulse rises in the same cycle as
    // the pick; the snapshot loads on that pulse and
    // the front end outputs follow a cycle later;
    // the result strobe trails the done pulse by one.
    channel_sequencer #(
        .NUM_CH(NUM_CH),
        .IDX_W(IDX_W),
        .SETTLE_CYCLES(SETTLE_CYCLES)
    ) u_sequencer (
        .clk(clk),
        .rst_b(rst_b),
        .run(convertRun),
        .enables(setupWord.channelEnableBits),
        .channel(seqChannel),
        .startPulse(seqStart),
        .donePulse(seqDone),
        .busy(seqBusy)
    );

    assign conversionStart = seqStart;
    assign converting = seqBusy;

    // ----------------------------------------
    // Channel of the conversion in flight
    // ----------------------------------------
    // The sequencer moves on to its next pick at the
    // edge that ends a conversion, so the result is
    // tagged from this copy, not from the live pick.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            activeChannel <= '0;
        end else if (seqStart) begin
            activeChannel <= seqChannel;
        end
    end

    // ----------------------------------------
    // Per-conversion setup snapshot
    // ----------------------------------------
    // A write mid-conversion would corrupt the
    // settling filter, so fields move only here.
    // Trade-off: one conversion always runs on one
    // setup, at the price of a conversion of lag.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            activeSetup <= adc_setup_pkg::setup_s'(`SETUP_RESET);
        end else if (seqStart) begin
            activeSetup <= setupWord;
        end
    end

    // ----------------------------------------
    // Analog front end controls
    // ----------------------------------------
    // Limitation: bypassing the buffer drops the
    // probe currents at once; a host that wants the
    // probes must keep the buffer in the path.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bufferEnable <= 1'b0;
            burnoutEnable <= 1'b0;
        end else begin
            bufferEnable <= activeSetup.bufferOn;
            burnoutEnable <= activeSetup.burnout & activeSetup.bufferOn;
        end
    end

    // Coding and range for the modulator
    // Both come from the snapshot, never the live word
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            unipolarCoding <= 1'b0;
            gainSelect <= `GAIN_UNITY;
        end else begin
            unipolarCoding <= activeSetup.unipolar;
            gainSelect <= activeSetup.gainSelect;
        end
    end

    // Multiplexer selection for the input switch
    // One cycle behind the sequencer, so the switch
    // moves with the snapshot, a cycle ahead of the front end outputs.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            channelSelect <= '0;
        end else begin
            channelSelect <= seqChannel;
        end
    end

    // ----------------------------------------
    // Reference presence check
    // ----------------------------------------
    // The comparator is only meaningful while the
    // modulator runs, so idle time leaves the flag
    // frozen at its last sampled value.
    // There is no software clear: only a later
    // conversion, sampling the detector again or
    // running with the check off, can lower the flag.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            missingReferenceFlag <= 1'b0;
        end else if (seqBusy) begin
            if (activeSetup.referencePresenceCheckEnable) begin
                missingReferenceFlag <= refBelowThreshold;
            end else begin
                // Check disabled: nothing to report
                missingReferenceFlag <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Result delivery
    // ----------------------------------------
    // Strobe marks a settled result, one cycle long
    // A host polling for data must catch this cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resultValid <= 1'b0;
        end else begin
            resultValid <= seqDone;
        end
    end

    // Data and its tags, held until the next result
    // Filter data is taken on the done pulse, so the
    // filter must hold it valid through that cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resultData <= '0;
            resultChannel <= '0;
            resultUnipolar <= 1'b0;
            resultGain <= `GAIN_UNITY;
        end else if (seqDone) begin
            resultData <= filterData;
            resultChannel <= activeChannel;
            // Tag with the setup actually used
            resultUnipolar <= activeSetup.unipolar;
            resultGain <= activeSetup.gainSelect;
        end
    end

endmodule

// [adc_setup_props.sv]
`timescale 1ns/1ps

module adc_setup_props #(
    parameter int SETTLE_CYCLES = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic setupWrite,
    input wire logic [23:0] setupWriteData,
    input wire logic [23:0] setupReadData,
    input wire logic setupWriteDone,
    input wire logic convertRun,
    input wire logic refBelowThreshold,
    input wire logic bufferEnable,
    input wire logic burnoutEnable,
    input wire logic conversionStart,
    input wire logic converting,
    input wire logic resultValid,
    input wire logic missingReferenceFlag
);
    default clocking cb @(posedge clk); endclocking
    // Start pulse to result strobe: settling plus the strobe flop
    localparam int SETTLE_DELAY = SETTLE_CYCLES + 1;
    default disable iff (!rst_b);

    // Word on the write port one edge back
    logic [23:0] lastData;

    // Kept so the stored word can be compared a cycle late
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lastData <= 24'h000000;
        end else begin
            lastData <= setupWriteData;
        end
    end

    sequence s_written;
        ##1 setupWriteDone && setupReadData[23:6] == lastData[23:6];
    endsequence
    sequence s_settled;
        ##SETTLE_DELAY resultValid;
    endsequence

    property p_write_done;
        setupWrite |-> s_written;
    endproperty
    property p_write_hold;
        !setupWrite |=> $stable(setupReadData) && !setupWriteDone;
    endproperty
    property p_reserved;
        setupReadData[5] == 1'b0;
    endproperty
    property p_gain_code;
        setupReadData[2:0] != 3'h1;
    endproperty
    property p_gain_kept;
        setupWrite && setupWriteData[2:0] == 3'h1
            |=> $stable(setupReadData[2:0]);
    endproperty
    property p_burnout;
        burnoutEnable |-> bufferEnable;
    endproperty
    property p_settle;
        conversionStart |-> s_settled;
    endproperty
    property p_start;
        !converting && convertRun && setupReadData[17:8] != 10'h000
            |=> conversionStart && converting;
    endproperty
    property p_flag_hold;
        !converting |=> $stable(missingReferenceFlag);
    endproperty
    property p_flag_clear;
        converting && !refBelowThreshold |=> !missingReferenceFlag;
    endproperty

    a_write_done: assert property (p_write_done)
        else $error("setup write not stored with done pulse");
    a_write_hold: assert property (p_write_hold)
        else $error("setup word changed without a write");
    a_reserved: assert property (p_reserved)
        else $error("reserved setup bit reads one");
    a_gain_code: assert property (p_gain_code)
        else $error("reserved gain code stored");
    a_gain_kept: assert property (p_gain_kept)
        else $error("gain changed by reserved code");
    a_burnout: assert property (p_burnout)
        else $error("probe current on with buffer off");
    a_settle: assert property (p_settle)
        else $error("result not delivered after settling");
    a_start: assert property (p_start)
        else $error("conversion did not start");
    a_flag_hold: assert property (p_flag_hold)
        else $error("reference flag moved while idle");
    a_flag_clear: assert property (p_flag_clear)
        else $error("reference flag set with reference good");
endmodule

bind adc_channel_range_setup adc_setup_props #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) i_adc_setup_props (
    .clk(clk), .rst_b(rst_b), .setupWrite(setupWrite),
    .setupWriteData(setupWriteData), .setupReadData(setupReadData),
    .setupWriteDone(setupWriteDone), .convertRun(convertRun),
    .refBelowThreshold(refBelowThreshold), .bufferEnable(bufferEnable),
    .burnoutEnable(burnoutEnable), .conversionStart(conversionStart),
    .converting(converting), .resultValid(resultValid),
    .missingReferenceFlag(missingReferenceFlag)
);

// [host_model.sv]
`timescale 1ns/1ps

module host_model (
    input wire logic clk,
    output logic setupWrite,
    output logic [23:0] setupWriteData
);
    // Port quiet until the first write
    initial begin
        setupWrite = 1'b0;
        setupWriteData = 24'h000000;
    end

    // Whole word per write; raw lets a test break the host's habits
    // no calibration issued
    task automatic write(input logic [23:0] w, input logic raw);
        logic [23:0] d;
        d = w;
        if (!raw) d[5] = 1'b0;
        if (!raw && w[2:0] == 3'h1) d[2:0] = 3'h0;
        @(negedge clk);
        setupWrite = 1'b1;
        setupWriteData = d;
        @(negedge clk);
        setupWrite = 1'b0;
        // Stale bus must not look like the last word
        setupWriteData = ~d;
    endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`include "adc_setup_consts.svh"

module tb_top;
    localparam int S = 3; // Short settling keeps the run brief
    logic clk, rst_b, convertRun, refBelowThreshold, setupWrite;
    logic setupWriteDone, bufferEnable, burnoutEnable, unipolarCoding;
    logic converting, resultValid, resultUnipolar, missingReferenceFlag;
    logic [23:0] setupWriteData, setupReadData, filterData, resultData;
    logic [23:0] fdPrev, shadow, word;
    logic [3:0] resultChannel, channelSelect;
    logic [2:0] gainSelect, resultGain;
    logic [3:0] seqCh [4] = '{4'h0, 4'h2, 4'h9, 4'h0};
    int failures, checks, seed, fdSeed;

    adc_channel_range_setup #(.SETTLE_CYCLES(S)) i_adc_channel_range_setup (
        .clk(clk), .rst_b(rst_b), .setupWrite(setupWrite),
        .setupWriteData(setupWriteData), .setupReadData(setupReadData),
        .setupWriteDone(setupWriteDone), .convertRun(convertRun),
        .refBelowThreshold(refBelowThreshold), .filterData(filterData),
        .bufferEnable(bufferEnable), .burnoutEnable(burnoutEnable),
        .unipolarCoding(unipolarCoding), .gainSelect(gainSelect),
        .channelSelect(channelSelect), .conversionStart(),
        .converting(converting),
        .resultValid(resultValid), .resultData(resultData),
        .resultChannel(resultChannel), .resultUnipolar(resultUnipolar),
        .resultGain(resultGain), .missingReferenceFlag(missingReferenceFlag)
    );
    host_model i_host_model (
        .clk(clk), .setupWrite(setupWrite), .setupWriteData(setupWriteData)
    );

    // ----------
    // Helpers
    // ----------
    task automatic stop_test;
        $display("TB: %0d checks, %0d failures", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask

    // Stored word: bit five cleared, gain code one keeps old gain
    function automatic logic [23:0] clean(logic [23:0] w, logic [23:0] o);
        clean = w;
        clean[5] = 1'b0;
        if (w[2:0] == 3'h1) clean[2:0] = o[2:0];
    endfunction

    task automatic wr(input logic [23:0] w, input logic raw);
        i_host_model.write(w, raw);
        shadow = clean(w, shadow);
        chk(setupReadData, shadow);
        chk(setupWriteDone, 1'b1);
    endtask

    // Bounded wait for the next result, channel checked if asked
    task automatic get_result(input logic [3:0] ch, input logic en);
        int n;
        @(negedge clk);
        for (n = 0; n < 40 && resultValid !== 1'b1; n++) @(negedge clk);
        if (n == 40) begin
            failures++;
            stop_test();
        end
        if (en) chk(resultChannel, ch);
    endtask

    // ----------
    // Clock and filter data
    // ----------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Result must carry the data present at its settling edge
    always @(negedge clk) begin
        fdPrev = filterData;
        if (resultValid === 1'b1) chk(resultData, fdPrev);
        filterData = 24'($random(fdSeed));
    end

    // ----------
    // Main sequence
    // ----------
    initial begin
        seed = 32'h58b12bed;
        fdSeed = 32'h58b12bed;
        rst_b = 1'b0;
        convertRun = 1'b0;
        refBelowThreshold = 1'b0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        shadow = `SETUP_RESET;
        chk(setupReadData, shadow);
        chk(bufferEnable, 1'b1);
        chk(gainSelect, 3'h7);
        $display("TB: reset test done");
        // All gain codes, reserved one too, then random raw words
        for (int i = 0; i < 20; i++) begin
            word = 24'($random(seed));
            if (i < 8) word[2:0] = i[2:0];
            wr(word, 1'b1);
        end
        $display("TB: write test done");
        // Channels 0, 2 and short; probe, buffer, unipolar, gain 4
        wr(24'h02059C, 1'b0);
        convertRun = 1'b1;
        foreach (seqCh[k]) get_result(seqCh[k], 1'b1);
        chk(burnoutEnable, 1'b1);
        chk(unipolarCoding, 1'b1);
        chk(resultGain, 3'h4);
        // Buffer off and bipolar, written mid conversion
        wr(24'h020584, 1'b0);
        get_result(4'h2, 1'b1);
        get_result(4'h9, 1'b1);
        chk(burnoutEnable, 1'b0);
        chk(bufferEnable, 1'b0);
        chk(resultUnipolar, 1'b0);
        $display("TB: sequence test done");
        // Each single channel in turn
        for (int k = 0; k < 10; k++) begin
            wr(24'h000010 | (24'h000100 << k), 1'b0);
            // Up to two results may still carry the old pick
            get_result(4'h0, 1'b0);
            get_result(4'h0, 1'b0);
            get_result(k[3:0], 1'b1);
            chk(channelSelect, k[3:0]);
        end
        $display("TB: channel test done");
        // Missing reference seen only while converting
        wr(24'h000150, 1'b0);
        refBelowThreshold = 1'b1;
        // Up to two results may still come from channel nine
        get_result(4'h0, 1'b0);
        get_result(4'h0, 1'b0);
        get_result(4'h0, 1'b1);
        chk(missingReferenceFlag, 1'b1);
        convertRun = 1'b0;
        get_result(4'h0, 1'b1);
        chk(converting, 1'b0);
        refBelowThreshold = 1'b0;
        repeat (5) @(negedge clk);
        chk(missingReferenceFlag, 1'b1);
        convertRun = 1'b1;
        get_result(4'h0, 1'b1);
        get_result(4'h0, 1'b1);
        chk(missingReferenceFlag, 1'b0);
        convertRun = 1'b0;
        $display("TB: reference test done");
        stop_test();
    end
endmodule
